/* core/fifo_ctl_pkg.sv */
// Constants shared by the FIFO reset, configuration and retransmit control.
// Assumes a single reference clock; all pins are sampled by the core.
`default_nettype none

package fifo_ctl_pkg;
	// =========================================================
	// Data path
	localparam int DATA_W = 18;
	localparam int NARROW_W = 9;
	localparam int OFFSET_W = 16;
	localparam int SYNC_STAGES = 2;
	localparam int PIN_W = 32;

	// =========================================================
	// Captured configuration layout
	localparam int CFG_W = 8;
	localparam int CFG_FWFT = 0;
	localparam int CFG_RD_NARROW = 1;
	localparam int CFG_WR_NARROW = 2;
	localparam int CFG_LITTLE_END = 3;
	localparam int CFG_NORMAL_RT = 4;
	localparam int CFG_SYNC_FLAGS = 5;
	localparam int CFG_PARITY = 6;
	localparam int CFG_PARALLEL = 7;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

	// =========================================================
	// Offset register defaults (plain value, reloaded on full reset)
	localparam logic [OFFSET_W-1:0] EMPTY_OFFSET_RESET = 16'h007f;
	localparam logic [OFFSET_W-1:0] FULL_OFFSET_RESET = 16'h007f;

	// =========================================================
	// Read side sequencing
	typedef enum logic [1:0] {
		RD_RUN = 2'b01,
		RD_SETUP = 2'b10
	} rd_state_e;
endpackage : fifo_ctl_pkg

`default_nettype wire

/* core/fifo_reset_retransmit_control.sv */
// FIFO core with full/soft reset, strap capture and retransmit control.
// Assumes write and read clocks arrive as pins, sampled by ref_clk (>= 4x faster).
//
// Summary of operation
// R1: Flag timing select is latched in full reset; high means synchronous flag timing.
// R2: Soft reset keeps read mode, offsets, widths, byte order, parity, latency mode.
// R3: 18-bit read mode drives all outputs; 9-bit mode only the low nine.
// R4: Read edge with read enable reads a word or an offset register.
// R5: Retransmit latency select latched in full reset; low means zero latency.
// R6: Reread request rewinds read pointer; empty low or output-valid; writes kept.
// R7: Write edge writes word or parallel offset; serial enable shifts one bit.
// R8: Writer uses all eighteen inputs, or only low nine in 9-bit mode.
// R9: Full reset zeroes pointers; almost-empty low, almost-full and half high.
// R10: Fall-through select sampled in full reset picks fall-through or standard mode.
// R11: Widths, byte order, latency, flag timing, parity captured only in full reset.
// R12: Full reset is asynchronous, clears output register; needed before first write.
// R13: Soft reset zeroes pointers and sets the same flag levels as full reset.
// R14: Soft reset keeps read mode and drives its mode-specific flag levels.
// R15: Soft reset keeps offsets and method, clears output register, acts asynchronously.
// R16: Reader starts setup with reread low; normal latency needs enables idle first.
// R17: In zero latency the reader may keep read enable asserted.
// R18: Fall-through retransmit: valid drops, then first word appears without read enable.
// R19: Standard retransmit: empty low during setup, reads then need read enable.
// R20: Zero latency loads first word on the same edge that saw reread.
// R21: With read and reread idle, standard mode holds the output register; fall-through refills it when empty.
`timescale 1ns/10ps
`default_nettype none

module fifo_reset_retransmit_control #(
	parameter int DEPTH = 8192
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic full_reset_n,
	input wire logic soft_reset_n,
	input wire logic write_clk,
	input wire logic write_enable_n,
	input wire logic [fifo_ctl_pkg::DATA_W-1:0] write_data,
	input wire logic serial_load_enable_n,
	input wire logic load_n,
	input wire logic fall_through_select,
	input wire logic read_clk,
	input wire logic read_enable_n,
	input wire logic reread_request_n,
	input wire logic read_width_select,
	input wire logic write_width_select,
	input wire logic byte_order_select,
	input wire logic retransmit_latency_select,
	input wire logic flag_timing_select,
	input wire logic parity_interleave_select,
	output logic [fifo_ctl_pkg::DATA_W-1:0] read_data,
	output logic empty_n,
	output logic full_n,
	output logic almost_empty_flag,
	output logic almost_full_flag,
	output logic half_level_flag,
	output logic [fifo_ctl_pkg::CFG_W-1:0] config_status
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	initial begin
		if (DEPTH < 4 || (1 << AW) != DEPTH || CW > 31) begin
			$error("DEPTH must be a power of two from 4 to 2**30");
		end
	end

	// Zeroes the upper half when the port runs nine bits wide
	function automatic logic [fifo_ctl_pkg::DATA_W-1:0] fit_width(
		input logic [fifo_ctl_pkg::DATA_W-1:0] word,
		input logic narrow
	);
		logic [fifo_ctl_pkg::DATA_W-1:0] mask;
		mask = {{(fifo_ctl_pkg::DATA_W - fifo_ctl_pkg::NARROW_W){~narrow}},
			{fifo_ctl_pkg::NARROW_W{1'b1}}};
		return word & mask;
	endfunction : fit_width

	// =========================================================
	// Reset synchronisers: assertion is immediate, release is clocked
	logic [1:0] sys_rst_r;
	logic [1:0] full_rst_r;
	logic [1:0] soft_rst_r;
	logic rst_n_s;
	logic full_rst_n_s;
	logic area_rst_n;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sys_rst_r <= 2'h0;
		end else begin
			sys_rst_r <= {sys_rst_r[0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn or negedge full_reset_n) begin
		if (!rstn || !full_reset_n) begin
			full_rst_r <= 2'h0; // R12
		end else begin
			full_rst_r <= {full_rst_r[0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn or negedge soft_reset_n) begin
		if (!rstn || !soft_reset_n) begin
			soft_rst_r <= 2'h0; // R15
		end else begin
			soft_rst_r <= {soft_rst_r[0], 1'b1};
		end
	end

	assign rst_n_s = sys_rst_r[1];
	assign full_rst_n_s = full_rst_r[1];
	// Pointer, flag and output state clears on any reset pin
	assign area_rst_n = rst_n_s & full_rst_r[1] & soft_rst_r[1]; // R9 R13

	// =========================================================
	// Pin synchronisers
	logic [fifo_ctl_pkg::PIN_W-1:0] pin_raw;
	logic [fifo_ctl_pkg::PIN_W-1:0] pin_meta_r;
	logic [fifo_ctl_pkg::PIN_W-1:0] pin_s_r;
	logic wclk_d_r;
	logic rclk_d_r;

	// One copy of load_n serves both the access steering and the method strap
	assign pin_raw = {write_data, write_clk, write_enable_n, serial_load_enable_n, load_n,
		fall_through_select, read_clk, read_enable_n, reread_request_n,
		parity_interleave_select, flag_timing_select,
		retransmit_latency_select, byte_order_select, write_width_select,
		read_width_select};

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pin_meta_r <= '0;
			pin_s_r <= '0;
			wclk_d_r <= 1'b0;
			rclk_d_r <= 1'b0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_s_r <= pin_meta_r;
			wclk_d_r <= pin_s_r[13];
			rclk_d_r <= pin_s_r[8];
		end
	end

	wire [fifo_ctl_pkg::DATA_W-1:0] wdata_s = pin_s_r[31:14];
	wire wclk_s = pin_s_r[13];
	wire wen_n_s = pin_s_r[12];
	wire sen_n_s = pin_s_r[11];
	wire ld_n_s = pin_s_r[10];
	wire si_s = pin_s_r[9];
	wire rclk_s = pin_s_r[8];
	wire ren_n_s = pin_s_r[7];
	wire rt_n_s = pin_s_r[6];
	// Straps, ordered as the configuration layout; the fall-through strap is si
	wire [fifo_ctl_pkg::CFG_W-1:0] strap_s = {ld_n_s, pin_s_r[5:0], si_s};
	wire wclk_rise = wclk_s & ~wclk_d_r;
	wire rclk_rise = rclk_s & ~rclk_d_r;

	// =========================================================
	// Configuration captured only while full reset is held
	logic [fifo_ctl_pkg::CFG_W-1:0] cfg_r;

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			cfg_r <= fifo_ctl_pkg::CFG_RESET;
		end else if (!full_rst_n_s) begin
			cfg_r <= strap_s; // R1 R5 R10 R11
		end
	end

	wire fwft = cfg_r[fifo_ctl_pkg::CFG_FWFT];
	wire rd_narrow = cfg_r[fifo_ctl_pkg::CFG_RD_NARROW];
	wire wr_narrow = cfg_r[fifo_ctl_pkg::CFG_WR_NARROW];
	wire zero_rt = ~cfg_r[fifo_ctl_pkg::CFG_NORMAL_RT];
	wire sync_flags = cfg_r[fifo_ctl_pkg::CFG_SYNC_FLAGS];
	wire parallel_prog = cfg_r[fifo_ctl_pkg::CFG_PARALLEL];
	assign config_status = cfg_r;

	// =========================================================
	// Offset registers: survive soft reset, reload defaults on full reset
	logic [fifo_ctl_pkg::OFFSET_W-1:0] empty_off_r;
	logic [fifo_ctl_pkg::OFFSET_W-1:0] full_off_r;
	logic off_wsel_r;
	logic off_rsel_r;

	wire ser_shift = wclk_rise & ~ld_n_s & ~sen_n_s & ~parallel_prog;
	wire par_write = wclk_rise & ~ld_n_s & ~wen_n_s & parallel_prog;
	wire off_read = rclk_rise & ~ld_n_s & ~ren_n_s & rt_n_s;

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			empty_off_r <= fifo_ctl_pkg::EMPTY_OFFSET_RESET;
			full_off_r <= fifo_ctl_pkg::FULL_OFFSET_RESET;
		end else if (!full_rst_n_s) begin
			empty_off_r <= fifo_ctl_pkg::EMPTY_OFFSET_RESET;
			full_off_r <= fifo_ctl_pkg::FULL_OFFSET_RESET;
		end else if (ser_shift) begin
			{empty_off_r, full_off_r} <= {empty_off_r[fifo_ctl_pkg::OFFSET_W-2:0],
				full_off_r, si_s}; // R7
		end else if (par_write && !off_wsel_r) begin
			empty_off_r <= wdata_s[fifo_ctl_pkg::OFFSET_W-1:0]; // R7
		end else if (par_write) begin
			full_off_r <= wdata_s[fifo_ctl_pkg::OFFSET_W-1:0];
		end
	end

	// Parallel access alternates empty then full offset; soft reset restarts it
	always_ff @(posedge ref_clk or negedge area_rst_n) begin
		if (!area_rst_n) begin
			off_wsel_r <= 1'b0;
			off_rsel_r <= 1'b0;
		end else begin
			off_wsel_r <= off_wsel_r ^ par_write;
			off_rsel_r <= off_rsel_r ^ off_read;
		end
	end

	// =========================================================
	// Storage and pointers
	logic [fifo_ctl_pkg::DATA_W-1:0] mem_r [DEPTH];
	logic [CW-1:0] wptr_r;
	logic [CW-1:0] rptr_r;
	logic [CW-1:0] rptr_nxt;
	logic [CW-1:0] level;

	assign level = wptr_r - rptr_r;
	wire mem_empty = (level == '0);
	wire mem_full = (level == CW'(DEPTH));
	wire wr_go = wclk_rise & ~wen_n_s & ld_n_s & ~mem_full; // R7

	always_ff @(posedge ref_clk) begin
		if (wr_go) begin
			mem_r[wptr_r[AW-1:0]] <= fit_width(wdata_s, wr_narrow); // R8
		end
	end

	// =========================================================
	// Read side decode
	fifo_ctl_pkg::rd_state_e rd_state_r;
	fifo_ctl_pkg::rd_state_e rd_state_nxt;
	logic valid_r;
	logic valid_nxt;
	logic [fifo_ctl_pkg::DATA_W-1:0] q_r;
	logic [fifo_ctl_pkg::DATA_W-1:0] q_nxt;

	wire in_setup = (rd_state_r == fifo_ctl_pkg::RD_SETUP);
	wire rt_go = rclk_rise & ~rt_n_s; // R6 R16
	wire rd_req = rclk_rise & rt_n_s & ~ren_n_s & ld_n_s;
	wire std_rd = rd_req & ~fwft & ~in_setup & ~mem_empty; // R4 R19
	// Fall-through refill: empty output stage, a taken read, or setup end
	wire fwft_fill = rclk_rise & rt_n_s & fwft & ~mem_empty &
		(~valid_r | (~ren_n_s & ld_n_s)); // R18
	wire fwft_drain = rd_req & fwft & valid_r & mem_empty;
	wire load_word = std_rd | fwft_fill;
	wire zero_hit = zero_rt & (wptr_r != '0);
	wire [fifo_ctl_pkg::DATA_W-1:0] mem_head = mem_r[rptr_r[AW-1:0]];
	wire [fifo_ctl_pkg::DATA_W-1:0] mem_first = mem_r[0];
	wire [fifo_ctl_pkg::DATA_W-1:0] off_word = off_rsel_r ?
		fifo_ctl_pkg::DATA_W'(full_off_r) : fifo_ctl_pkg::DATA_W'(empty_off_r);

	// Rewind wins over any read on the same edge, so zero latency tolerates REN low
	assign rptr_nxt = rt_go ? (zero_hit ? CW'(1) : '0) :
		load_word ? rptr_r + CW'(1) : rptr_r; // R6 R17
	assign q_nxt = (rt_go && zero_hit) ? fit_width(mem_first, rd_narrow) :
		rt_go ? q_r :
		load_word ? fit_width(mem_head, rd_narrow) :
		off_read ? fit_width(off_word, rd_narrow) : q_r; // R3 R4 R20 R21
	assign valid_nxt = rt_go ? zero_hit :
		fwft_fill ? 1'b1 : (fwft_drain ? 1'b0 : valid_r); // R18 R20

	always_comb begin
		rd_state_nxt = rd_state_r;
		unique case (rd_state_r)
			fifo_ctl_pkg::RD_RUN: begin
				if (rt_go && !zero_rt) begin
					rd_state_nxt = fifo_ctl_pkg::RD_SETUP; // R6
				end
			end
			fifo_ctl_pkg::RD_SETUP: begin
				if (rclk_rise && rt_n_s) begin
					rd_state_nxt = fifo_ctl_pkg::RD_RUN; // R19
				end
			end
			default: begin
				rd_state_nxt = fifo_ctl_pkg::RD_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge area_rst_n) begin
		if (!area_rst_n) begin
			wptr_r <= '0; // R9 R13
			rptr_r <= '0;
			q_r <= '0; // R12 R15
			valid_r <= 1'b0; // R14
			rd_state_r <= fifo_ctl_pkg::RD_RUN;
		end else begin
			wptr_r <= wr_go ? wptr_r + CW'(1) : wptr_r;
			rptr_r <= rptr_nxt;
			q_r <= q_nxt;
			valid_r <= valid_nxt;
			rd_state_r <= rd_state_nxt;
		end
	end

	assign read_data = q_r;

	// =========================================================
	// Status flags
	logic ae_r;
	logic af_r;
	logic hf_r;

	wire [31:0] held = 32'(level) + (fwft ? 32'(valid_r) : 32'h0);
	wire [31:0] free = 32'(DEPTH) - 32'(level);
	wire ae_val = held > 32'(empty_off_r);
	wire af_val = free > 32'(full_off_r);
	// Synchronous timing moves almost-empty and almost-full only on their own clock's edge; half level follows ref_clk
	wire ae_upd = ~sync_flags | rclk_rise; // R1
	wire af_upd = ~sync_flags | wclk_rise; // R1

	always_ff @(posedge ref_clk or negedge area_rst_n) begin
		if (!area_rst_n) begin
			ae_r <= 1'b0; // R9 R13
			af_r <= 1'b1;
			hf_r <= 1'b1;
		end else begin
			ae_r <= ae_upd ? ae_val : ae_r;
			af_r <= af_upd ? af_val : af_r;
			hf_r <= ~(32'(level) > 32'(DEPTH / 2));
		end
	end

	assign almost_empty_flag = ae_r;
	assign almost_full_flag = af_r;
	assign half_level_flag = hf_r;
	// Shared pins: empty or output-ready, full or input-ready, per captured mode
	assign empty_n = fwft ? ~valid_r : (~in_setup & ~mem_empty); // R14 R19
	assign full_n = fwft ? mem_full : ~mem_full; // R10 R14
endmodule : fifo_reset_retransmit_control

`default_nettype wire

/* test/fifo_ctl_properties.sv */
// Port-level checks of reset clearing, strap capture and output hold.
// Assumes straps stay steady while full reset is low.
`timescale 1ns/10ps
`default_nettype none
module fifo_ctl_properties (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic full_reset_n,
	input wire logic soft_reset_n,
	input wire logic read_clk,
	input wire logic fall_through_select,
	input wire logic read_width_select,
	input wire logic write_width_select,
	input wire logic byte_order_select,
	input wire logic retransmit_latency_select,
	input wire logic flag_timing_select,
	input wire logic parity_interleave_select,
	input wire logic [fifo_ctl_pkg::DATA_W-1:0] read_data,
	input wire logic empty_n,
	input wire logic full_n,
	input wire logic almost_empty_flag,
	input wire logic almost_full_flag,
	input wire logic half_level_flag,
	input wire logic [fifo_ctl_pkg::CFG_W-1:0] config_status
);
	// ========
	// Helpers
	logic [2:0] quiet_r;
	logic [2:0] quiet_nxt;
	wire rst_lvl = ~almost_empty_flag & almost_full_flag & half_level_flag & (read_data == 18'h0);
	wire ft = config_status[fifo_ctl_pkg::CFG_FWFT];
	wire std_lvl = ~empty_n & full_n;
	wire ft_lvl = empty_n & ~full_n;
	// Capture runs late through the syncs, so count quiet cycles first
	assign quiet_nxt = (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			quiet_r <= 3'h0;
		else
			quiet_r <= full_reset_n ? quiet_nxt : 3'h0;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence held;
		(!full_reset_n && $stable({fall_through_select, read_width_select, write_width_select,
			byte_order_select, retransmit_latency_select, flag_timing_select,
			parity_interleave_select}))[*8];
	endsequence
	// ========
	// Assertions
	chk_full_rst_clear: assert property (!full_reset_n |-> rst_lvl)
		else $error("full reset left flags or data set");
	chk_soft_rst_clear: assert property (!soft_reset_n |-> rst_lvl)
		else $error("soft reset left flags or data set");
	chk_fwft_capture: assert property (held |-> ft == fall_through_select
		&& (fall_through_select ? ft_lvl : std_lvl)) else $error("mode strap not captured");
	chk_latency_capture: assert property (held |->
		config_status[4] == retransmit_latency_select) else $error("latency strap lost");
	chk_flag_mode: assert property (held |->
		config_status[5] == flag_timing_select) else $error("flag timing strap lost");
	chk_width_capture: assert property (held |-> {config_status[6], config_status[3:1]} ==
		{parity_interleave_select, byte_order_select, write_width_select, read_width_select})
		else $error("width or order strap lost");
	chk_soft_keeps_cfg: assert property (quiet_r == 3'h7 && !soft_reset_n |=>
		$stable(config_status)) else $error("soft reset changed configuration");
	chk_soft_mode_flags: assert property (quiet_r == 3'h7 && !soft_reset_n |->
		(ft ? ft_lvl : std_lvl)) else $error("soft reset flags wrong for mode");
	chk_narrow_read: assert property (config_status[1] |-> read_data[17:9] == 9'h000)
		else $error("upper outputs driven in narrow mode");
	chk_idle_hold: assert property ((full_reset_n && soft_reset_n && !read_clk)[*8]
		##1 (full_reset_n && soft_reset_n) |-> $stable(read_data)) else $error("data moved");
	cover property (!soft_reset_n && ft);
	cover property (config_status[1] && read_data != 18'h0);
	cover property ($fell(empty_n) && !config_status[4] && ft);
endmodule : fifo_ctl_properties
`default_nettype wire

/* test/fifo_link_model.sv */
// Writer and reader on the link pins; one frame per call.
// Assumes link clocks stand still between frames.
`timescale 1ns/10ps
`default_nettype none
module fifo_link_model (
	output var logic write_clk,
	output var logic write_enable_n,
	output var logic [fifo_ctl_pkg::DATA_W-1:0] write_data,
	output var logic read_clk,
	output var logic read_enable_n,
	output var logic reread_request_n
);
	initial begin
		write_clk = 1'b0;
		read_clk = 1'b0;
		write_enable_n = 1'b1;
		read_enable_n = 1'b1;
		reread_request_n = 1'b1;
		write_data = 18'h15555;
	end
	// ========
	// Frames
	// Released bus shows the inverse so stale data never looks valid
	task automatic wr(input logic [fifo_ctl_pkg::DATA_W-1:0] d);
		#1.3;
		write_enable_n = 1'b0;
		write_data = d;
		#62.5 write_clk = 1'b1;
		#62.5 write_clk = 1'b0;
		write_enable_n = 1'b1;
		write_data = ~d;
	endtask : wr
	task automatic rd(input logic ren_n, input logic rt_n);
		#1.3;
		read_enable_n = ren_n;
		reread_request_n = rt_n;
		#62.5 read_clk = 1'b1;
		#62.5 read_clk = 1'b0;
		read_enable_n = 1'b1;
		reread_request_n = 1'b1;
	endtask : rd
endmodule : fifo_link_model
`default_nettype wire

/* test/fifo_reset_retransmit_control_test.sv */
// Bench: resets, strap capture, reads and both retransmit latencies.
// Assumes the link model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module fifo_reset_retransmit_control_test;
	logic ref_clk, rstn, full_reset_n, soft_reset_n, fall_through_select;
	logic read_width_select, write_width_select, byte_order_select;
	logic retransmit_latency_select, flag_timing_select, parity_interleave_select;
	logic write_clk, write_enable_n, read_clk, read_enable_n, reread_request_n;
	logic [17:0] write_data, read_data;
	logic empty_n, full_n, almost_empty_flag, almost_full_flag, half_level_flag;
	logic [7:0] config_status, exp_cfg;
	int failures = 0;
	int n_compared = 0;
	fifo_reset_retransmit_control #(.DEPTH(16)) dut (.ref_clk, .rstn, .full_reset_n,
		.soft_reset_n, .write_clk, .write_enable_n, .write_data, .serial_load_enable_n(1'b1),
		.load_n(1'b1), .fall_through_select, .read_clk, .read_enable_n, .reread_request_n,
		.read_width_select, .write_width_select, .byte_order_select, .retransmit_latency_select,
		.flag_timing_select, .parity_interleave_select, .read_data, .empty_n, .full_n,
		.almost_empty_flag, .almost_full_flag, .half_level_flag, .config_status);
	fifo_link_model link (.write_clk, .write_enable_n, .write_data, .read_clk,
		.read_enable_n, .reread_request_n);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ========
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [17:0] flags();
		return {13'h0, empty_n, full_n, almost_empty_flag, almost_full_flag, half_level_flag};
	endfunction : flags
	function automatic logic [17:0] wd(input int i);
		return 18'h2b4c1 + 18'(i) * 18'h01111;
	endfunction : wd
	task automatic mrst(input logic ft, input logic rm, input logic ow);
		@(posedge ref_clk);
		full_reset_n <= 1'b0;
		fall_through_select <= ft;
		retransmit_latency_select <= rm;
		read_width_select <= ow;
		flag_timing_select <= ~rm;
		parity_interleave_select <= ft;
		byte_order_select <= ow;
		exp_cfg = {1'b1, ft, ~rm, rm, ow, 1'b0, ow, ft};
		cyc(12);
		check({10'h0, config_status}, {10'h0, exp_cfg});
		check(flags(), ft ? 18'h13 : 18'h0b);
		check(read_data, 18'h0);
		full_reset_n <= 1'b1;
		cyc(8);
	endtask : mrst
	task automatic srst(input logic [17:0] fl);
		@(posedge ref_clk);
		soft_reset_n <= 1'b0;
		cyc(8);
		check(flags(), fl);
		check(read_data, 18'h0);
		soft_reset_n <= 1'b1;
		cyc(8);
		check({10'h0, config_status}, {10'h0, exp_cfg});
	endtask : srst
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// ========
	// Tests
	initial begin
		{rstn, full_reset_n, soft_reset_n, fall_through_select, read_width_select} = 5'h04;
		{write_width_select, byte_order_select, retransmit_latency_select} = 3'h0;
		{flag_timing_select, parity_interleave_select} = 2'h0;
		cyc(5);
		rstn <= 1'b1;
		cyc(4);
		mrst(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) link.wr(wd(i));
		check({17'h0, empty_n}, 18'h1);
		link.rd(1'b0, 1'b1);
		check(read_data, wd(0));
		link.rd(1'b0, 1'b1);
		link.rd(1'b1, 1'b1);
		check(read_data, wd(1));
		link.rd(1'b1, 1'b0);
		check({17'h0, empty_n}, 18'h0);
		link.rd(1'b1, 1'b1);
		check({17'h0, empty_n}, 18'h1);
		link.rd(1'b0, 1'b1);
		check(read_data, wd(0));
		srst(18'h0b);
		mrst(1'b1, 1'b0, 1'b1);
		link.wr(wd(0));
		link.wr(wd(1));
		link.rd(1'b1, 1'b1);
		check(read_data, wd(0) & 18'h001ff);
		link.rd(1'b0, 1'b1);
		check(read_data, wd(1) & 18'h001ff);
		link.rd(1'b0, 1'b0);
		check(read_data, wd(0) & 18'h001ff);
		srst(18'h13);
		conclude();
	end
	initial begin
		#20000;
		failures++;
		$display("watchdog expired at %0t", $time);
		conclude();
	end
endmodule : fifo_reset_retransmit_control_test
bind fifo_reset_retransmit_control fifo_ctl_properties props (.ref_clk, .rstn, .full_reset_n,
	.soft_reset_n, .read_clk, .fall_through_select, .read_width_select, .write_width_select,
	.byte_order_select, .retransmit_latency_select, .flag_timing_select,
	.parity_interleave_select, .read_data, .empty_n, .full_n, .almost_empty_flag,
	.almost_full_flag, .half_level_flag, .config_status);
`default_nettype wire
